// ==== src/swl_pkg.sv ====
// Purpose: Shared constants and types for the single-wire slave ROM layer.
// Assumes: 40 MHz system clock.
// Notes:   All bus timing is counted in microsecond ticks from a divider.
package swl_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned US_PER_S        = 1000000;
    localparam int unsigned CYC_PER_US      = CLK_HZ / US_PER_S;
    localparam int unsigned RESET_LOW_US    = 480;
    localparam int unsigned PRES_WAIT_US    = 30;
    localparam int unsigned PRES_LOW_US     = 120;
    localparam int unsigned SAMPLE_US       = 30;
    localparam int unsigned TX_ZERO_US      = 45;
    localparam logic [5:0]  US_DIV_LAST     = 6'(CYC_PER_US - 1);
    localparam logic [9:0]  RESET_LOW_TICKS = 10'(RESET_LOW_US);
    localparam logic [9:0]  PRES_WAIT_TICKS = 10'(PRES_WAIT_US);
    localparam logic [9:0]  PRES_LOW_TICKS  = 10'(PRES_LOW_US);
    localparam logic [9:0]  SAMPLE_TICKS    = 10'(SAMPLE_US);
    localparam logic [9:0]  TX_ZERO_TICKS   = 10'(TX_ZERO_US);

    // ------------------------------------------------------------------
    // Commands and identity
    // ------------------------------------------------------------------
    localparam logic [7:0]  CMD_READ_ROM    = 8'h33;
    localparam logic [7:0]  CMD_MATCH_ROM   = 8'h55;
    localparam logic [7:0]  CMD_SKIP_ROM    = 8'hCC;
    localparam logic [7:0]  CMD_SEARCH_ROM  = 8'hF0;
    localparam logic [7:0]  CRC_POLY_REV    = 8'h8C;
    localparam int unsigned ID_BITS         = 64;
    localparam int unsigned FIFO_WIDTH      = 8;
    localparam int unsigned FIFO_DEPTH      = 16;

    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_PWAIT   = 9'h002,
        ST_PLOW    = 9'h004,
        ST_CMD     = 9'h008,
        ST_READROM = 9'h010,
        ST_MATCH   = 9'h020,
        ST_SEARCH  = 9'h040,
        ST_FUNC    = 9'h080,
        ST_DESEL   = 9'h100
    } swl_state_type;

    // Slot phase within one master time slot.
    typedef enum logic [2:0] {
        SL_WAIT   = 3'h1,
        SL_ACTIVE = 3'h2,
        SL_REL    = 3'h4
    } swl_slot_type;

endpackage

// ==== src/swl_fifo_if.sv ====
// Purpose: Valid/ready carrier between the link engine and its FIFO.
// Assumes: Single clock domain.
// Notes:   Push side and pop side each have a modport.
`timescale 1ns/10ps
`default_nettype none
interface swl_fifo_if;
    logic [7:0] data;
    logic       valid;
    logic       ready;
    modport src (output data, output valid, input ready);
    modport dst (input data, input valid, output ready);
endinterface
`default_nettype wire

// ==== src/swl_fifo.sv ====
// Purpose: Parameterised FIFO with valid/ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Read data comes from a register; full and empty are exact.
`timescale 1ns/10ps
`default_nettype none
module swl_fifo
    import swl_pkg::*;
#(
    parameter int unsigned WIDTH = FIFO_WIDTH,
    parameter int unsigned DEPTH = FIFO_DEPTH
)(
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output var  logic             in_ready_o,
    output var  logic [WIDTH-1:0] out_data_o,
    output var  logic             out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      rd_reg;
    logic             full;
    logic             avail;
    logic             do_push;
    logic             do_pop;

    assign full    = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    assign avail   = (wr_reg != rd_reg);
    assign do_push = in_valid_i && !full;
    // Output register refills when it is empty or being consumed.
    assign do_pop  = avail && (!out_valid_o || out_ready_i);

    always_ff @(posedge clk_sys_i)
    begin
        if (do_push)
        begin
            mem[wr_reg[AW-1:0]] <= in_data_i;
        end
        if (rst_i)
        begin
            wr_reg      <= '0;
            rd_reg      <= '0;
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
            in_ready_o  <= 1'b0;
        end
        else
        begin
            if (do_push)
            begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (do_pop)
            begin
                rd_reg      <= rd_reg + 1'b1;
                out_data_o  <= mem[rd_reg[AW-1:0]];
                out_valid_o <= 1'b1;
            end
            else if (out_ready_i)
            begin
                out_valid_o <= 1'b0;
            end
            in_ready_o <= !full;
        end
    end
endmodule // swl_fifo
`default_nettype wire

// ==== src/swl_slave.sv ====
// Purpose: Slave side of a single-wire multidrop bus, up to the ROM layer.
// Assumes: Line input is synchronous to clk_sys_i; pull-up outside.
// Notes:   Function command bytes go out through a 16-byte FIFO.
//
// Function
// R1 - Everything travels least significant bit first.
// R2 - Pin only pulls low or releases.
// R3 - Idle high; pauses between bits allowed.
// R4 - Low over 480 us resets the slave.
// R5 - Order: init, ROM command, function, data.
// R6 - Master sends one eight-bit ROM command.
// R7 - Read ROM sends family, serial, CRC.
// R8 - Master uses read ROM with one slave.
// R9 - Match ROM mismatch ignores bus until reset.
// R10 - Skip ROM goes straight to function command.
// R11 - Master avoids reads after skip when multidrop.
// R12 - Search sends bit, complement, samples master bit.
// R13 - Search mismatch drops out for the pass.
// R14 - Master decodes bit/complement pairs.
// R15 - Master resets with 480 us low.
// R16 - Presence after 15-60 us, 60-240 us low.
// R17 - Master starts every signal except presence.
// R18 - Function commands locked until ROM step done.
// R19 - Check byte is CRC x8+x5+x4+1 over 56.
// R20 - Standard-speed slot timing, sample near 15 us; the slave samples at 30 us after the falling edge.
`timescale 1ns/10ps
`default_nettype none
module swl_slave
    import swl_pkg::*;
#(
    // Arbitrary neutral identity; the check byte is computed, not stored.
    parameter logic [7:0]  FAMILY_CODE = 8'hA5,
    parameter logic [47:0] SERIAL_NUM  = 48'h0000_0000_0001
)(
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       line_i,
    output var  logic       line_o,
    output var  logic       line_oe_n_o,
    output var  logic [7:0] func_data_o,
    output var  logic       func_valid_o,
    input  wire logic       func_ready_i,
    output var  logic       func_overrun_o,
    output var  logic       rom_done_o,
    output var  logic       bus_reset_o
);

    // ------------------------------------------------------------------
    // Identity code with check byte
    // ------------------------------------------------------------------
    function automatic logic [7:0] crc_of(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++)
        begin
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1); // [R19]
        end
        return c;
    endfunction

    localparam logic [55:0] ID_LOW = {SERIAL_NUM, FAMILY_CODE};
    localparam logic [63:0] ID_CODE = {crc_of(ID_LOW), ID_LOW};

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        swl_state_type st;
        swl_slot_type  slot;
        logic [5:0]    div;
        logic [9:0]    low_cnt;
        logic [9:0]    tmr;
        logic          line_d;
        logic [6:0]    bitn;
        logic [1:0]    phase;
        logic          tx_bit;
        logic [7:0]    shreg;
        logic          pull;
        logic [7:0]    fdata;
        logic          fvalid;
        logic          overrun;
        logic          done;
        logic          brst;
    } swl_regs_type;

    swl_regs_type s_reg;
    swl_regs_type s_next;
    swl_fifo_if   fq ();

    logic         us_tick;
    logic         fall;
    logic         id_bit;

    assign us_tick = (s_reg.div == US_DIV_LAST);
    assign fall    = s_reg.line_d && !line_i;
    assign id_bit  = ID_CODE[s_reg.bitn[5:0]]; // [R1]
    assign fq.data  = s_reg.fdata;
    assign fq.valid = s_reg.fvalid;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic smp;
        logic done_bit;
        smp      = 1'b0;
        done_bit = 1'b0;
        s_next   = s_reg;
        s_next.line_d = line_i;
        s_next.div    = us_tick ? 6'h00 : s_reg.div + 6'h01;
        s_next.brst   = 1'b0;
        if (fq.ready)
        begin
            s_next.fvalid = 1'b0;
        end

        // A long low counts in microseconds; any high restarts the count.
        if (line_i)
        begin
            s_next.low_cnt = 10'h000;
        end
        else if (us_tick && s_reg.low_cnt != RESET_LOW_TICKS)
        begin
            s_next.low_cnt = s_reg.low_cnt + 10'h001;
        end

        // Slot engine: master starts each slot by a falling edge.
        case (s_reg.slot)
            SL_WAIT:
            begin
                if (fall && s_reg.st != ST_IDLE && s_reg.st != ST_PWAIT
                    && s_reg.st != ST_PLOW && s_reg.st != ST_DESEL) // [R17]
                begin
                    s_next.slot = SL_ACTIVE;
                    s_next.tmr  = 10'h000;
                    s_next.pull = !s_reg.tx_bit && (s_reg.st == ST_READROM
                        || (s_reg.st == ST_SEARCH && s_reg.phase != 2'h2)); // [R2]
                end
            end
            SL_ACTIVE:
            begin
                if (us_tick)
                begin
                    s_next.tmr = s_reg.tmr + 10'h001;
                end
                if (us_tick && s_reg.tmr == SAMPLE_TICKS)
                begin
                    smp = 1'b1; // [R20]
                end
                if (us_tick && s_reg.tmr == TX_ZERO_TICKS)
                begin
                    s_next.pull = 1'b0;
                    s_next.slot = SL_REL;
                end
            end
            SL_REL:
            begin
                // Any pause is fine while the line rests high.
                if (line_i)
                begin
                    s_next.slot = SL_WAIT; // [R3]
                end
            end
            default:
            begin
                s_next.slot = SL_WAIT;
            end
        endcase

        // Receive shift register, one bit per slot.
        if (smp)
        begin
            s_next.shreg = {line_i, s_reg.shreg[7:1]}; // [R1]
        end

        case (s_reg.st)
            ST_IDLE:
            begin
                s_next.tx_bit = 1'b0;
            end
            ST_PWAIT:
            begin
                if (us_tick)
                begin
                    s_next.tmr = s_reg.tmr + 10'h001;
                end
                if (us_tick && s_reg.tmr == PRES_WAIT_TICKS)
                begin
                    s_next.st   = ST_PLOW;
                    s_next.tmr  = 10'h000;
                    s_next.pull = 1'b1; // [R16]
                end
            end
            ST_PLOW:
            begin
                if (us_tick)
                begin
                    s_next.tmr = s_reg.tmr + 10'h001;
                end
                if (us_tick && s_reg.tmr == PRES_LOW_TICKS)
                begin
                    s_next.st   = ST_CMD;
                    s_next.pull = 1'b0; // [R16]
                    s_next.bitn = 7'h00;
                    s_next.slot = SL_REL;
                end
            end
            ST_CMD:
            begin
                if (smp && s_reg.bitn == 7'h07)
                begin
                    s_next.bitn  = 7'h00;
                    s_next.phase = 2'h0;
                    // Exactly one eight-bit ROM command follows presence.
                    if ({line_i, s_reg.shreg[7:1]} == CMD_READ_ROM) // [R6]
                    begin
                        s_next.st     = ST_READROM;
                        s_next.tx_bit = ID_CODE[0]; // [R7]
                    end
                    else if ({line_i, s_reg.shreg[7:1]} == CMD_MATCH_ROM)
                    begin
                        s_next.st = ST_MATCH;
                    end
                    else if ({line_i, s_reg.shreg[7:1]} == CMD_SKIP_ROM)
                    begin
                        s_next.st   = ST_FUNC; // [R10]
                        s_next.done = 1'b1;
                    end
                    else if ({line_i, s_reg.shreg[7:1]} == CMD_SEARCH_ROM)
                    begin
                        s_next.st     = ST_SEARCH;
                        s_next.tx_bit = ID_CODE[0]; // [R12]
                    end
                    else
                    begin
                        s_next.st = ST_DESEL;
                    end
                end
                else if (smp)
                begin
                    s_next.bitn = s_reg.bitn + 7'h01;
                end
            end
            ST_READROM:
            begin
                if (smp)
                begin
                    done_bit      = (s_reg.bitn == 7'(ID_BITS - 1));
                    s_next.bitn   = s_reg.bitn + 7'h01;
                    s_next.tx_bit = ID_CODE[6'(s_reg.bitn + 7'h01)]; // [R7]
                    if (done_bit)
                    begin
                        s_next.st     = ST_FUNC;
                        s_next.done   = 1'b1;
                        s_next.bitn   = 7'h00;
                        s_next.tx_bit = 1'b0;
                    end
                end
            end
            ST_MATCH:
            begin
                if (smp)
                begin
                    s_next.bitn = s_reg.bitn + 7'h01;
                    if (line_i != id_bit)
                    begin
                        s_next.st = ST_DESEL; // [R9]
                    end
                    else if (s_reg.bitn == 7'(ID_BITS - 1))
                    begin
                        s_next.st   = ST_FUNC;
                        s_next.done = 1'b1;
                        s_next.bitn = 7'h00;
                    end
                end
            end
            ST_SEARCH:
            begin
                if (smp)
                begin
                    case (s_reg.phase)
                        2'h0:
                        begin
                            s_next.phase  = 2'h1;
                            s_next.tx_bit = ~id_bit; // [R12]
                        end
                        2'h1:
                        begin
                            s_next.phase  = 2'h2;
                            s_next.tx_bit = 1'b0;
                        end
                        default:
                        begin
                            s_next.phase  = 2'h0;
                            s_next.bitn   = s_reg.bitn + 7'h01;
                            s_next.tx_bit = ID_CODE[6'(s_reg.bitn + 7'h01)];
                            if (line_i != id_bit)
                            begin
                                s_next.st     = ST_DESEL; // [R13]
                                s_next.tx_bit = 1'b0;
                            end
                            else if (s_reg.bitn == 7'(ID_BITS - 1))
                            begin
                                s_next.st     = ST_FUNC;
                                s_next.done   = 1'b1;
                                s_next.bitn   = 7'h00;
                                s_next.tx_bit = 1'b0;
                            end
                        end
                    endcase
                end
            end
            ST_FUNC:
            begin
                // Bytes past the ROM step go to the function layer.
                if (smp && s_reg.bitn == 7'h07 && s_reg.done) // [R18]
                begin
                    s_next.bitn = 7'h00;
                    if (fq.ready)
                    begin
                        s_next.fdata  = {line_i, s_reg.shreg[7:1]}; // [R5]
                        s_next.fvalid = 1'b1;
                    end
                    else
                    begin
                        s_next.overrun = 1'b1;
                    end
                end
                else if (smp)
                begin
                    s_next.bitn = s_reg.bitn + 7'h01;
                end
            end
            ST_DESEL:
            begin
                s_next.tx_bit = 1'b0;
                s_next.pull   = 1'b0;
            end
            default:
            begin
                s_next.st = ST_IDLE;
            end
        endcase

        // A low past the reset time aborts the transaction but keeps the overrun flag; its release starts presence.
        if (s_reg.low_cnt == RESET_LOW_TICKS)
        begin
            s_next.st    = ST_IDLE;
            s_next.slot  = SL_WAIT;
            s_next.pull  = 1'b0;
            s_next.done  = 1'b0; // [R4]
            s_next.brst  = !line_i && s_reg.st != ST_IDLE;
            if (line_i)
            begin
                s_next.st  = ST_PWAIT; // [R16]
                s_next.tmr = 10'h000;
                s_next.low_cnt = 10'h000;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            s_reg       <= '0;
            s_reg.st    <= ST_IDLE;
            s_reg.slot  <= SL_WAIT;
            s_reg.line_d <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            line_o      <= 1'b0;
            line_oe_n_o <= 1'b1;
            rom_done_o  <= 1'b0;
            bus_reset_o <= 1'b0;
            func_overrun_o <= 1'b0;
        end
        else
        begin
            line_o      <= 1'b0; // [R2]
            line_oe_n_o <= !s_next.pull;
            rom_done_o  <= s_next.done;
            bus_reset_o <= s_next.brst;
            func_overrun_o <= s_next.overrun;
        end
    end

    swl_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_data_i   (fq.data),
        .in_valid_i  (fq.valid),
        .in_ready_o  (fq.ready),
        .out_data_o  (func_data_o),
        .out_valid_o (func_valid_o),
        .out_ready_i (func_ready_i)
    );

endmodule // swl_slave
`default_nettype wire

// ==== dv/swl_slave_chk.sv ====
// Purpose: Port-level checks on the single-wire slave.
// Assumes: One clock domain, reset rst_i.
// Notes:   Counters measure line and pull lengths in clock cycles.
`timescale 1ns/10ps
`default_nettype none
module swl_slave_chk
    import swl_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       line_i,
    input  wire logic       line_o,
    input  wire logic       line_oe_n_o,
    input  wire logic [7:0] func_data_o,
    input  wire logic       func_valid_o,
    input  wire logic       func_ready_i,
    input  wire logic       func_overrun_o,
    input  wire logic       rom_done_o,
    input  wire logic       bus_reset_o
);
    // ------------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------------
    logic [14:0] low_cnt_reg;
    logic [13:0] pull_cnt_reg;
    logic [9:0]  hi_cnt_reg;
    logic        arm_reg;
    logic [11:0] wait_cnt_reg;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            low_cnt_reg  <= '0;
            pull_cnt_reg <= '0;
            hi_cnt_reg   <= '0;
            arm_reg      <= 1'b0;
            wait_cnt_reg <= '0;
        end
        else
        begin
            low_cnt_reg  <= line_i ? '0 : low_cnt_reg + 15'(low_cnt_reg != '1);
            pull_cnt_reg <= line_oe_n_o ? '0 : pull_cnt_reg + 14'(pull_cnt_reg != '1);
            hi_cnt_reg   <= !line_i ? '0 : hi_cnt_reg + 10'(hi_cnt_reg != '1);
            wait_cnt_reg <= !(arm_reg && line_oe_n_o) ? '0 : wait_cnt_reg + 12'h001;
            if (line_i && low_cnt_reg >= 15'h4B00)
                arm_reg <= 1'b1;
            else if (line_oe_n_o && pull_cnt_reg != '0)
                arm_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    drive_low_a: assert property (line_o == 1'b0)
        else $error("bus pin driven to a level other than low");
    rst_quiet_a: assert property (disable iff (1'b0) rst_i |=> line_oe_n_o && !rom_done_o)
        else $error("pin or status active during reset");
    pres_quiet_a: assert property (arm_reg && line_i && hi_cnt_reg < 10'h258 |-> line_oe_n_o)
        else $error("presence started too early");
    pres_due_a: assert property (arm_reg |-> wait_cnt_reg <= 12'h960)
        else $error("presence missing after reset pulse");
    pres_len_a: assert property ($rose(line_oe_n_o) && arm_reg |->
        pull_cnt_reg >= 14'h960 && pull_cnt_reg <= 14'h2580)
        else $error("presence length out of range");
    hold_bound_a: assert property (pull_cnt_reg <= 14'h2580)
        else $error("line held low too long by the slave");
    slave_start_a: assert property ($fell(line_oe_n_o) && !arm_reg |-> $past(line_i) == 1'b0)
        else $error("slave pulled without a master slot");
    abandon_a: assert property (low_cnt_reg >= 15'h4B28 |-> !rom_done_o)
        else $error("transaction kept through a bus reset");
    reset_flag_a: assert property (bus_reset_o |-> !line_i && low_cnt_reg >= 15'h4AD0)
        else $error("bus reset flag without a long low");
    func_gate_a: assert property ($rose(func_valid_o) |-> rom_done_o)
        else $error("function byte before ROM step");

    cover property ($fell(line_oe_n_o) && arm_reg);
    cover property ($rose(rom_done_o));
    cover property (func_valid_o && func_ready_i);
endmodule // swl_slave_chk

bind swl_slave swl_slave_chk swl_slave_chk_i (
    .clk_sys_i     (clk_sys_i),
    .rst_i         (rst_i),
    .line_i        (line_i),
    .line_o        (line_o),
    .line_oe_n_o   (line_oe_n_o),
    .func_data_o   (func_data_o),
    .func_valid_o  (func_valid_o),
    .func_ready_i  (func_ready_i),
    .func_overrun_o(func_overrun_o),
    .rom_done_o    (rom_done_o),
    .bus_reset_o   (bus_reset_o)
);
`default_nettype wire

// ==== dv/swl_master_mdl.sv ====
// Purpose: Behavioural bus master with the line pull-up.
// Assumes: 40 cycles to a microsecond; changes land on falling clock edges.
// Notes:   Slots last 55 us so the slave's 46 us hold always ends inside.
`timescale 1ns/10ps
`default_nettype none
module swl_master_mdl (
    input  wire logic clk_sys_i,
    input  wire logic slave_oe_n_i,
    output wire logic line_o
);
    logic m_low = 1'b0;

    // The pull-up lifts the line when nobody pulls it low.
    assign line_o = !m_low && slave_oe_n_i;

    task automatic wait_us(input int n);
        repeat (n * 40) @(negedge clk_sys_i);
    endtask

    task automatic reset_pulse(output int gap, output int len);
        m_low = 1'b1;
        wait_us(490);
        m_low = 1'b0;
        gap = 0;
        len = 0;
        repeat (8000)
        begin
            @(negedge clk_sys_i);
            if (!line_o)
                len++;
            else if (len == 0)
                gap++;
        end
    endtask

    task automatic write_bit(input logic b);
        m_low = 1'b1;
        wait_us(b ? 2 : 50);
        m_low = 1'b0;
        wait_us(b ? 53 : 5);
    endtask

    task automatic read_bit(output logic b);
        m_low = 1'b1;
        wait_us(2);
        m_low = 1'b0;
        wait_us(11);
        b = line_o;
        wait_us(42);
    endtask

    task automatic write_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            write_bit(v[i]);
    endtask

    task automatic read_byte(output logic [7:0] v);
        logic b;
        for (int i = 0; i < 8; i++)
        begin
            read_bit(b);
            v[i] = b;
        end
    endtask
endmodule // swl_master_mdl
`default_nettype wire

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench for the single-wire slave.
// Assumes: Master model drives the line; pull-up inside the model.
// Notes:   Full 64-bit reads are cut short to keep the run brief.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import swl_pkg::*;
;
    // Arbitrary family value; bits 0 to 2 are 0, 1, 0.
    localparam logic [7:0] FAM = 8'h9A;

    logic       clk_sys_i    = 1'b0;
    logic       rst_i        = 1'b1;
    logic       func_ready_i = 1'b0;
    wire logic  line_i;
    logic       line_o;
    logic       line_oe_n_o;
    logic [7:0] func_data_o;
    logic       func_valid_o;
    logic       rom_done_o;
    logic       func_overrun_o;
    int         mismatches   = 0;
    int         checks_done  = 0;

    swl_slave #(.FAMILY_CODE(FAM)) swl_slave_i (
        .clk_sys_i     (clk_sys_i),
        .rst_i         (rst_i),
        .line_i        (line_i),
        .line_o        (line_o),
        .line_oe_n_o   (line_oe_n_o),
        .func_data_o   (func_data_o),
        .func_valid_o  (func_valid_o),
        .func_ready_i  (func_ready_i),
        .func_overrun_o(func_overrun_o),
        .rom_done_o    (rom_done_o),
        .bus_reset_o   ()
    );

    swl_master_mdl swl_master_mdl_i (
        .clk_sys_i   (clk_sys_i),
        .slave_oe_n_i(line_oe_n_o),
        .line_o      (line_i)
    );

    initial
    begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (mismatches == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic init_seq();
        int gap;
        int len;
        swl_master_mdl_i.reset_pulse(gap, len);
        chk(64'(gap >= 600 && gap <= 2400), 64'h1);
        chk(64'(len >= 2400 && len <= 9600), 64'h1);
        chk(64'(rom_done_o), 64'h0);
    endtask

    task automatic s_skip();
        init_seq();
        swl_master_mdl_i.write_byte(CMD_SKIP_ROM);
        chk(64'(rom_done_o), 64'h1);
        swl_master_mdl_i.wait_us(200);
        swl_master_mdl_i.write_byte(8'h35);
        repeat (10) @(negedge clk_sys_i);
        chk(64'(func_valid_o), 64'h1);
        chk(64'(func_data_o), 64'h35);
        chk(64'(func_overrun_o), 64'h0);
        func_ready_i = 1'b1;
        @(negedge clk_sys_i);
        func_ready_i = 1'b0;
        @(negedge clk_sys_i);
        chk(64'(func_valid_o), 64'h0);
    endtask

    task automatic s_read();
        logic [7:0] v;
        init_seq();
        swl_master_mdl_i.write_byte(CMD_READ_ROM);
        swl_master_mdl_i.read_byte(v);
        chk(64'(v), 64'(FAM));
    endtask

    task automatic s_search();
        logic b;
        logic c;
        init_seq();
        swl_master_mdl_i.write_byte(CMD_SEARCH_ROM);
        for (int k = 0; k < 2; k++)
        begin
            swl_master_mdl_i.read_bit(b);
            swl_master_mdl_i.read_bit(c);
            chk(64'(b), 64'(FAM[k]));
            chk(64'(c), 64'(!FAM[k]));
            swl_master_mdl_i.write_bit(k == 0 ? FAM[0] : !FAM[1]);
        end
        swl_master_mdl_i.read_bit(b);
        swl_master_mdl_i.read_bit(c);
        chk(64'({b, c}), 64'h3);
    endtask

    initial
    begin
        repeat (6) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        s_skip();
        s_read();
        s_search();
        conclude();
    end

    initial
    begin
        #7000000;
        mismatches++;
        conclude();
    end
endmodule // tb_top
`default_nettype wire
